// ===== verilog/mpp_pkg.sv
// shared constants and types of the modem parameter and packetizer block
`default_nettype none
package mpp_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int GAP_UNIT_NS = 200000; // 0.2 ms
    localparam int GAP_UNIT_CYCLES = GAP_UNIT_NS / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // register word offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PARITY = 8'h00;
    localparam logic [7:0] OFS_BOOT = 8'h04;
    localparam logic [7:0] OFS_MAXPKT = 8'h08;
    localparam logic [7:0] OFS_PINWAKE = 8'h0c;
    localparam logic [7:0] OFS_TRIG = 8'h10;
    localparam logic [7:0] OFS_GAP = 8'h14;
    localparam logic [7:0] OFS_AIRRATE = 8'h18;
    localparam logic [7:0] OFS_SLEEPKIND = 8'h1c;
    localparam logic [7:0] OFS_IDLESLEEP = 8'h20;
    localparam logic [7:0] OFS_CMD = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQSTAT = 8'h2c;
    localparam logic [7:0] OFS_IRQMASK = 8'h30;
    // command register bits
    localparam int CMD_FACTORY = 0;
    localparam int CMD_COMMIT = 1;
    localparam int CMD_RELOAD = 2;
    localparam int CMD_EXITCMD = 3;
    // interrupt status bits
    localparam int IRQ_ALERT = 0;
    localparam int IRQ_REJECT = 1;
    localparam int IRQ_TXSTART = 2;
    localparam int IRQ_CMDWAKE = 3;
    localparam int IRQ_W = 4;
    // ----------------------------------------------------------------
    // ranges
    // ----------------------------------------------------------------
    localparam logic [2:0] PARITY_MAX = 3'h5;
    localparam logic [8:0] PKT_MAX = 9'h100;
    localparam logic [8:0] PKT_AIR0_CAP = 9'h100; // cap when air rate is 0
    localparam logic [1:0] SLEEP_CYCLIC = 2'h1;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] paritySelect;
        logic bootTarget;
        logic [8:0] maxPacketLen;
        logic pinWake;
        logic [8:0] charCountTrigger;
        logic [15:0] idleGapTimeout;
        logic [7:0] airRate;
        logic [1:0] sleepKind;
        logic [15:0] idleBeforeSleep;
    } mpp_cfg_s;
    localparam mpp_cfg_s CFG_FACTORY = '{
        paritySelect: 3'h0, bootTarget: 1'h0, maxPacketLen: 9'h040, pinWake: 1'h0,
        charCountTrigger: 9'h001, idleGapTimeout: 16'h0032, airRate: 8'h03,
        sleepKind: 2'h0, idleBeforeSleep: 16'h0064};
    typedef struct packed {
        logic first;
        logic last;
        logic [7:0] data;
    } mpp_beat_s;
endpackage
`default_nettype wire

// ===== verilog/mpp_core.sv
// parameter registers, serial input buffer and packetizer of the modem
//
// Summary of operation
// - parity selector 0..5, default 0
// - boot target picks idle or command mode
// - boot target, sleep kind 1: doze low wakes command
// - max packet length 0..0x100, caps packet size
// - air rate 0 clamps packet length to 256
// - lowering packet length pulls trigger down
// - pin wake 0 or 1, default 0
// - pin wake only counts when sleep kind is not 0
// - doze pin low keeps device awake
// - after doze raised, stay awake idle interval
// - start on gap timeout or byte count
// - later packets stream until buffer empty
// - trigger 0..packet length, default 1
// - factory load restores working settings only
// - settings persist only through explicit commit
// - one-byte and two-byte parameter read widths
// - gap timeout counts 0.2 ms units
`default_nettype none
module mpp_core #(
    parameter int BUF_DEPTH = 256,
    parameter int GAP_TICK_CYCLES = mpp_pkg::GAP_UNIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register bus
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    // serial receive side
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic rxReady,
    // radio transmit side
    output logic txValid,
    output mpp_pkg::mpp_beat_s txBeat,
    input wire logic txReady,
    // pins and mode
    input wire logic inputLineThree,
    output logic cmdMode,
    output logic sleepReq,
    output logic [2:0] uartParity
);
    localparam int PW = $clog2(BUF_DEPTH);
    typedef enum {ST_IDLE, ST_SEND} mpp_state_e;

    // ----------------------------------------------------------------
    // register bus slave
    // ----------------------------------------------------------------
    logic served;
    logic [7:0] byteAddr;
    logic acc;
    logic wrAcc;
    logic rdAcc;
    logic [31:0] rdMux;
    mpp_pkg::mpp_cfg_s cfg;
    mpp_pkg::mpp_cfg_s nvCfg;
    mpp_pkg::mpp_cfg_s next_cfg;
    logic [mpp_pkg::IRQ_W-1:0] irqStat;
    logic [mpp_pkg::IRQ_W-1:0] irqMask;
    logic [mpp_pkg::IRQ_W-1:0] irqSet;
    logic rejected;
    logic clamped;
    logic wrCmd;

    // one wait cycle per access; readdata loads in that cycle
    assign byteAddr = {address, 2'b00};
    assign acc = (read || write) && served;
    assign wrAcc = write && served;
    assign rdAcc = read && served;
    assign waitrequest = (read || write) && !served;
    assign wrCmd = wrAcc && byteAddr == mpp_pkg::OFS_CMD;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            served <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            served <= (read || write) && !served;
            if (read && !served) begin
                readdata <= rdMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial input buffer
    // ----------------------------------------------------------------
    logic [7:0] mem [BUF_DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] bufCount;
    logic push;
    logic pop;
    logic bufEmpty;

    assign bufEmpty = bufCount == '0;
    assign rxReady = bufCount != (PW+1)'(BUF_DEPTH); // back-pressure to the uart
    assign push = rxValid && rxReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= rxData;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            bufCount <= '0;
        end else begin
            wrPtr <= wrPtr + PW'(push);
            rdPtr <= rdPtr + PW'(pop);
            bufCount <= bufCount + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // ----------------------------------------------------------------
    // 0.2 ms units for the gap timer and the wake timer
    // ----------------------------------------------------------------
    logic [31:0] gapDiv;
    logic [31:0] unitDiv;
    logic gapTick;
    logic unitTick;
    logic [15:0] gapUnits;
    logic gapHit;

    assign gapTick = gapDiv == 32'(GAP_TICK_CYCLES - 1);
    assign unitTick = unitDiv == 32'(GAP_TICK_CYCLES - 1);
    assign gapHit = cfg.idleGapTimeout != 16'h0000 && gapUnits >= cfg.idleGapTimeout;

    // gap divider restarts on every byte so silence is measured from it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gapDiv <= 32'h0000_0000;
            unitDiv <= 32'h0000_0000;
            gapUnits <= 16'h0000;
        end else begin
            unitDiv <= unitTick ? 32'h0000_0000 : unitDiv + 32'h0000_0001;
            gapDiv <= (push || gapTick) ? 32'h0000_0000 : gapDiv + 32'h0000_0001;
            if (push) begin
                gapUnits <= 16'h0000;
            end else if (gapTick && gapUnits != 16'hffff) begin
                gapUnits <= gapUnits + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // packetizer
    // ----------------------------------------------------------------
    mpp_state_e state;
    logic [8:0] rxSince;
    logic [8:0] pktCnt;
    logic [8:0] pktLimit;
    logic cntHit;
    logic startTx;
    logic lastBeat;

    // a zero packet length still moves one byte per packet
    assign pktLimit = cfg.maxPacketLen == 9'h000 ? 9'h001 : cfg.maxPacketLen;
    assign cntHit = cfg.charCountTrigger != 9'h000 && rxSince >= cfg.charCountTrigger;
    assign startTx = state == ST_IDLE && !bufEmpty && (cntHit || gapHit
        || (cfg.charCountTrigger == 9'h000 && cfg.idleGapTimeout == 16'h0000));
    assign txValid = state == ST_SEND && !bufEmpty;
    assign pop = txValid && txReady;
    assign lastBeat = pktCnt + 9'h001 == pktLimit || bufCount == (PW+1)'(1);
    assign txBeat.data = mem[rdPtr];
    assign txBeat.first = pktCnt == 9'h000;
    assign txBeat.last = lastBeat;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            rxSince <= 9'h000;
            pktCnt <= 9'h000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (startTx) begin
                        state <= ST_SEND;
                    end else if (push && rxSince != 9'h1ff) begin
                        rxSince <= rxSince + 9'h001;
                    end
                end
                ST_SEND: begin
                    rxSince <= 9'h000;
                    if (pop) begin
                        pktCnt <= lastBeat ? 9'h000 : pktCnt + 9'h001;
                        // keep streaming while bytes remain buffered
                        if (bufCount == (PW+1)'(1) && !push) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sleep and mode control
    // ----------------------------------------------------------------
    logic dozePrev;
    logic dozeFall;
    logic cyclicOn;
    logic pinHeld;
    logic [15:0] awakeTimer;
    logic holdAwake;

    assign cyclicOn = cfg.sleepKind != 2'h0;
    assign pinHeld = cfg.pinWake && cyclicOn;
    assign dozeFall = dozePrev && !inputLineThree;
    assign holdAwake = pinHeld && (!inputLineThree || awakeTimer != 16'h0000);
    assign sleepReq = cyclicOn && !holdAwake && bufEmpty && state == ST_IDLE
        && !cmdMode;
    assign uartParity = cfg.paritySelect;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dozePrev <= 1'b1;
            awakeTimer <= 16'h0000;
            cmdMode <= mpp_pkg::CFG_FACTORY.bootTarget;
        end else begin
            dozePrev <= inputLineThree;
            if (!inputLineThree) begin
                awakeTimer <= cfg.idleBeforeSleep;
            end else if (unitTick && awakeTimer != 16'h0000) begin
                awakeTimer <= awakeTimer - 16'h0001;
            end
            if (cfg.bootTarget && cfg.sleepKind == mpp_pkg::SLEEP_CYCLIC && dozeFall) begin
                cmdMode <= 1'b1;
            end else if (wrCmd && writedata[mpp_pkg::CMD_RELOAD]) begin
                cmdMode <= nvCfg.bootTarget;
            end else if (wrCmd && writedata[mpp_pkg::CMD_EXITCMD]) begin
                cmdMode <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // parameter writes
    // ----------------------------------------------------------------
    // factory load and reload leave the stored copy untouched
    always_comb begin
        next_cfg = cfg;
        rejected = 1'b0;
        clamped = 1'b0;
        if (wrCmd && writedata[mpp_pkg::CMD_FACTORY]) begin
            next_cfg = mpp_pkg::CFG_FACTORY;
        end else if (wrCmd && writedata[mpp_pkg::CMD_RELOAD]) begin
            next_cfg = nvCfg;
        end else if (wrAcc) begin
            case (byteAddr)
                mpp_pkg::OFS_PARITY: begin
                    if (writedata > 32'(mpp_pkg::PARITY_MAX)) rejected = 1'b1;
                    else next_cfg.paritySelect = writedata[2:0];
                end
                mpp_pkg::OFS_BOOT: begin
                    if (writedata > 32'h1) rejected = 1'b1;
                    else next_cfg.bootTarget = writedata[0];
                end
                mpp_pkg::OFS_PINWAKE: begin
                    if (writedata > 32'h1) rejected = 1'b1;
                    else next_cfg.pinWake = writedata[0];
                end
                mpp_pkg::OFS_MAXPKT: begin
                    if (writedata > 32'(mpp_pkg::PKT_MAX)) begin
                        rejected = 1'b1;
                    end else begin
                        next_cfg.maxPacketLen = writedata[8:0];
                        if (writedata[8:0] < cfg.charCountTrigger) begin
                            next_cfg.charCountTrigger = writedata[8:0];
                        end
                    end
                end
                mpp_pkg::OFS_TRIG: begin
                    if (writedata > 32'(cfg.maxPacketLen)) rejected = 1'b1;
                    else next_cfg.charCountTrigger = writedata[8:0];
                end
                mpp_pkg::OFS_GAP: begin
                    if (writedata > 32'hffff) rejected = 1'b1;
                    else next_cfg.idleGapTimeout = writedata[15:0];
                end
                mpp_pkg::OFS_AIRRATE: begin
                    if (writedata > 32'hff) begin
                        rejected = 1'b1;
                    end else begin
                        next_cfg.airRate = writedata[7:0];
                        if (writedata[7:0] == 8'h00 && cfg.maxPacketLen > mpp_pkg::PKT_AIR0_CAP) begin
                            next_cfg.maxPacketLen = mpp_pkg::PKT_AIR0_CAP;
                            clamped = 1'b1;
                        end
                    end
                end
                mpp_pkg::OFS_SLEEPKIND: begin
                    if (writedata > 32'h3) rejected = 1'b1;
                    else next_cfg.sleepKind = writedata[1:0];
                end
                mpp_pkg::OFS_IDLESLEEP: begin
                    if (writedata > 32'hffff) rejected = 1'b1;
                    else next_cfg.idleBeforeSleep = writedata[15:0];
                end
                default: next_cfg = cfg;
            endcase
        end
    end

    // nonvolatile copy changes only on commit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= mpp_pkg::CFG_FACTORY;
            nvCfg <= mpp_pkg::CFG_FACTORY;
        end else begin
            cfg <= next_cfg;
            if (wrCmd && writedata[mpp_pkg::CMD_COMMIT]) begin
                nvCfg <= cfg;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts and read mux
    // ----------------------------------------------------------------
    assign irqSet = {cfg.bootTarget && cfg.sleepKind == mpp_pkg::SLEEP_CYCLIC && dozeFall,
        startTx, rejected, clamped};
    assign irq = |(irqStat & irqMask);

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqStat <= '0;
            irqMask <= '0;
        end else begin
            irqStat <= (irqStat & ~((wrAcc && byteAddr == mpp_pkg::OFS_IRQSTAT)
                ? writedata[mpp_pkg::IRQ_W-1:0] : '0)) | irqSet;
            if (wrAcc && byteAddr == mpp_pkg::OFS_IRQMASK) begin
                irqMask <= writedata[mpp_pkg::IRQ_W-1:0];
            end
        end
    end

    // one-byte parameters sit in bits 7:0, two-byte ones in 15:0
    always_comb begin
        case (byteAddr)
            mpp_pkg::OFS_PARITY: rdMux = {29'h0, cfg.paritySelect};
            mpp_pkg::OFS_BOOT: rdMux = {31'h0, cfg.bootTarget};
            mpp_pkg::OFS_MAXPKT: rdMux = {23'h0, cfg.maxPacketLen};
            mpp_pkg::OFS_PINWAKE: rdMux = {31'h0, cfg.pinWake};
            mpp_pkg::OFS_TRIG: rdMux = {23'h0, cfg.charCountTrigger};
            mpp_pkg::OFS_GAP: rdMux = {16'h0, cfg.idleGapTimeout};
            mpp_pkg::OFS_AIRRATE: rdMux = {24'h0, cfg.airRate};
            mpp_pkg::OFS_SLEEPKIND: rdMux = {30'h0, cfg.sleepKind};
            mpp_pkg::OFS_IDLESLEEP: rdMux = {16'h0, cfg.idleBeforeSleep};
            mpp_pkg::OFS_STATUS: rdMux = {13'h0, cmdMode, sleepReq, state == ST_SEND,
                16'(bufCount)};
            mpp_pkg::OFS_IRQSTAT: rdMux = {28'h0, irqStat};
            mpp_pkg::OFS_IRQMASK: rdMux = {28'h0, irqMask};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence seqWrite(logic [7:0] ofs);
        wrAcc && byteAddr == ofs;
    endsequence

    a_parity_reject: assert property (seqWrite(mpp_pkg::OFS_PARITY) ##0 writedata > 32'h5
        |=> $stable(cfg.paritySelect) && irqStat[mpp_pkg::IRQ_REJECT])
        else $error("parity write out of range was taken");
    a_trig_under_pkt: assert property (cfg.charCountTrigger <= cfg.maxPacketLen)
        else $error("trigger above packet length");
    a_pkt_in_range: assert property (cfg.maxPacketLen <= mpp_pkg::PKT_MAX)
        else $error("packet length out of range");
    a_factory_restore: assert property (wrCmd && writedata == 32'h1
        |=> cfg == mpp_pkg::CFG_FACTORY && $stable(nvCfg))
        else $error("factory load wrong");
    a_boot_wake_cmd: assert property (cfg.bootTarget && cfg.sleepKind == 2'h1 && dozeFall
        |=> cmdMode)
        else $error("no wake into command mode");
    a_pin_awake: assert property (pinHeld && !inputLineThree |-> !sleepReq)
        else $error("sleep while doze pin low");
    a_count_start: assert property (state == ST_IDLE && cntHit && !bufEmpty
        |=> state == ST_SEND)
        else $error("count trigger did not start sending");
    a_stream_more: assert property (pop && bufCount > (PW+1)'(2)
        |=> state == ST_SEND ##1 txValid)
        else $error("streaming stopped with data buffered");
    a_short_read: assert property (rdAcc && byteAddr == mpp_pkg::OFS_PARITY
        |-> readdata[31:8] == 24'h0)
        else $error("one-byte read wider than a byte");
    a_bus_answer: assert property ((read || write) && !served |=> !waitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// ===== test/mpp_host_model.sv
// host-side partner: feeds serial bytes, sinks radio beats, drives the doze pin
`default_nettype none
module mpp_host_model (
    // clock
    input wire logic clk,
    // serial feed
    output logic rxValid,
    output logic [7:0] rxData,
    input wire logic rxReady,
    // radio sink
    input wire logic txValid,
    input wire mpp_pkg::mpp_beat_s txBeat,
    output logic txReady,
    // doze pin, high = asserted
    output logic inputLineThree
);
    timeunit 1ns;
    timeprecision 1ps;
    mpp_pkg::mpp_beat_s got[$];
    logic slow;
    // idle levels; doze asserted so the pin only wakes when a test lowers it
    initial begin
        rxValid = 1'b0;
        rxData = 8'ha5;
        txReady = 1'b0;
        slow = 1'b0;
        inputLineThree = 1'b1;
    end
    // one byte per edge, held until taken; idle data flipped so it never looks stale
    task automatic sendBytes(input int n, input logic [7:0] base);
        @(posedge clk);
        for (int k = 0; k < n; k++) begin
            rxValid <= 1'b1;
            rxData <= base + 8'(k);
            do @(posedge clk); while (rxReady !== 1'b1);
        end
        rxValid <= 1'b0;
        rxData <= ~rxData;
    endtask
    // radio side stalls every other cycle when slow, to stretch packets
    always @(posedge clk) begin
        if (txValid === 1'b1 && txReady === 1'b1)
            got.push_back(txBeat);
        txReady <= slow ? ~txReady : 1'b1;
    end
endmodule
`default_nettype wire

// ===== test/modem_param_packetizer_test.sv
// self-checking bench of the modem parameter and packetizer block
`default_nettype none
module modem_param_packetizer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, read, write, waitrequest, irq, rxValid, rxReady, txValid, txReady;
    logic inputLineThree, cmdMode, sleepReq;
    logic [5:0] address;
    logic [31:0] writedata, readdata, d;
    logic [7:0] rxData;
    logic [2:0] uartParity;
    mpp_pkg::mpp_beat_s txBeat;
    int fails = 0;
    int nTests = 0;
    mpp_core #(.BUF_DEPTH(256), .GAP_TICK_CYCLES(4)) i_mpp_core (.clk(clk), .nrst(nrst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .rxValid(rxValid),
        .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txBeat(txBeat),
        .txReady(txReady), .inputLineThree(inputLineThree), .cmdMode(cmdMode),
        .sleepReq(sleepReq), .uartParity(uartParity));
    mpp_host_model i_mpp_host_model (.clk(clk), .rxValid(rxValid), .rxData(rxData),
        .rxReady(rxReady), .txValid(txValid), .txBeat(txBeat), .txReady(txReady),
        .inputLineThree(inputLineThree));
    // ----------------------------------------------------------------
    // bus and compare helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        nTests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task automatic wr(input logic [7:0] ofs, input logic [31:0] v);
        @(posedge clk);
        address <= ofs[7:2];
        writedata <= v;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ofs, output logic [31:0] v);
        @(posedge clk);
        address <= ofs[7:2];
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        v = readdata;
        read <= 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic resetValues();
        rd(mpp_pkg::OFS_PARITY, d); check(d, 32'h0, "parity default");
        rd(mpp_pkg::OFS_BOOT, d); check(d, 32'h0, "boot default");
        rd(mpp_pkg::OFS_MAXPKT, d); check(d, 32'h40, "pkt default");
        rd(mpp_pkg::OFS_PINWAKE, d); check(d, 32'h0, "wake default");
        rd(mpp_pkg::OFS_TRIG, d); check(d, 32'h1, "trig default");
        check({31'h0, cmdMode}, 32'h0, "boot to idle");
        check({31'h0, rxReady}, 32'h1, "buffer open");
    endtask
    // every parity code, then a refused code with its masked interrupt
    task automatic parityCodes();
        for (int v = 0; v < 6; v++) begin
            wr(mpp_pkg::OFS_PARITY, 32'(v));
            rd(mpp_pkg::OFS_PARITY, d); check(d, 32'(v), "parity");
            check({29'h0, uartParity}, 32'(v), "uart parity");
        end
        wr(mpp_pkg::OFS_IRQMASK, 32'h2);
        wr(mpp_pkg::OFS_PARITY, 32'h6);
        wr(mpp_pkg::OFS_BOOT, 32'h2);
        rd(mpp_pkg::OFS_PARITY, d); check(d, 32'h5, "parity refused");
        rd(mpp_pkg::OFS_BOOT, d); check(d, 32'h0, "boot refused");
        check({31'h0, irq}, 32'h1, "irq raised");
        wr(mpp_pkg::OFS_IRQSTAT, 32'h2);
        // the clear lands on the accepting edge; look one cycle later
        @(posedge clk);
        check({31'h0, irq}, 32'h0, "irq cleared");
    endtask
    task automatic lengthLinks();
        wr(mpp_pkg::OFS_MAXPKT, 32'h101);
        rd(mpp_pkg::OFS_MAXPKT, d); check(d, 32'h40, "pkt refused");
        wr(mpp_pkg::OFS_MAXPKT, 32'h100);
        rd(mpp_pkg::OFS_MAXPKT, d); check(d, 32'h100, "two byte pkt");
        wr(mpp_pkg::OFS_TRIG, 32'h80);
        wr(mpp_pkg::OFS_MAXPKT, 32'h4);
        rd(mpp_pkg::OFS_TRIG, d); check(d, 32'h4, "trig pulled");
        wr(mpp_pkg::OFS_TRIG, 32'h5);
        rd(mpp_pkg::OFS_TRIG, d); check(d, 32'h4, "trig above pkt");
    endtask
    // gap timer off, count of 4: three bytes wait, six bytes go as 4 + 2
    task automatic streamPackets();
        wr(mpp_pkg::OFS_GAP, 32'h0);
        i_mpp_host_model.slow = 1'b1;
        i_mpp_host_model.sendBytes(3, 8'h30);
        repeat (20) @(posedge clk);
        check(32'(i_mpp_host_model.got.size()), 32'h0, "early start");
        i_mpp_host_model.sendBytes(3, 8'h33);
        for (int t = 0; t < 200 && i_mpp_host_model.got.size() < 6; t++)
            @(posedge clk);
        check(32'(i_mpp_host_model.got.size()), 32'h6, "beat count");
        for (int k = 0; k < 6 && k < i_mpp_host_model.got.size(); k++)
            check({22'h0, i_mpp_host_model.got[k]},
                {22'h0, k % 4 == 0, k == 3 || k == 5, 8'h30 + 8'(k)}, "beat");
    endtask
    // count trigger off, gap of 2 units: one byte waits out the silence
    task automatic gapStart();
        wr(mpp_pkg::OFS_TRIG, 32'h0);
        wr(mpp_pkg::OFS_GAP, 32'h2);
        i_mpp_host_model.sendBytes(1, 8'h40);
        repeat (6) @(posedge clk);
        check(32'(i_mpp_host_model.got.size()), 32'h6, "gap too soon");
        repeat (12) @(posedge clk);
        check(32'(i_mpp_host_model.got.size()), 32'h7, "gap start");
        check({22'h0, i_mpp_host_model.got[6]}, {24'h3, 8'h40}, "gap beat");
    endtask
    task automatic dozeWake();
        wr(mpp_pkg::OFS_BOOT, 32'h1);
        wr(mpp_pkg::OFS_SLEEPKIND, 32'h1);
        wr(mpp_pkg::OFS_PINWAKE, 32'h1);
        wr(mpp_pkg::OFS_IDLESLEEP, 32'h2);
        i_mpp_host_model.inputLineThree <= 1'b0;
        repeat (4) @(posedge clk);
        check({31'h0, cmdMode}, 32'h1, "doze wake");
        // leave command mode first so only the low pin keeps it awake
        wr(mpp_pkg::OFS_CMD, 32'h8);
        @(posedge clk);
        check({31'h0, sleepReq}, 32'h0, "awake while low");
        i_mpp_host_model.inputLineThree <= 1'b1;
        repeat (2) @(posedge clk);
        check({31'h0, sleepReq}, 32'h0, "idle interval");
        repeat (60) @(posedge clk);
        check({31'h0, sleepReq}, 32'h1, "back to sleep");
    endtask
    // factory load touches working copy only; commit makes it stick
    task automatic factoryLoad();
        wr(mpp_pkg::OFS_PARITY, 32'h3);
        wr(mpp_pkg::OFS_CMD, 32'h2);
        wr(mpp_pkg::OFS_CMD, 32'h1);
        rd(mpp_pkg::OFS_PARITY, d); check(d, 32'h0, "factory parity");
        wr(mpp_pkg::OFS_CMD, 32'h4);
        rd(mpp_pkg::OFS_PARITY, d); check(d, 32'h3, "stored kept");
        wr(mpp_pkg::OFS_CMD, 32'h1);
        wr(mpp_pkg::OFS_CMD, 32'h2);
        wr(mpp_pkg::OFS_CMD, 32'h4);
        rd(mpp_pkg::OFS_PARITY, d); check(d, 32'h0, "committed");
    endtask
    // ----------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        resetValues();
        parityCodes();
        lengthLinks();
        streamPackets();
        gapStart();
        dozeWake();
        factoryLoad();
        results();
    end
    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200us;
        fails++;
        results();
    end
endmodule
`default_nettype wire
